// [rtl/reading_store_consts.svh]
`ifndef READING_STORE_CONSTS_SVH
`define READING_STORE_CONSTS_SVH

// register byte offsets
`define OFS_CTRL        12'h000
`define OFS_POINTS      12'h004
`define OFS_PRET_PCT    12'h008
`define OFS_PRET_READS  12'h00C
`define OFS_CMD         12'h010
`define OFS_STATUS      12'h014
`define OFS_FREE_AVAIL  12'h018
`define OFS_FREE_USED   12'h01C
`define OFS_RD_INDEX    12'h020
`define OFS_RD_READING  12'h024
`define OFS_RD_META     12'h028
`define OFS_RD_TIME     12'h02C

// control fields
`define CTRL_MODE_LO    0
`define CTRL_MODE_HI    1
`define CTRL_FEED_LO    2
`define CTRL_FEED_HI    3
`define CTRL_ELEMENT_SET_SELECT     4
`define CTRL_AUTO       5

// command bits
`define CMD_CLEAR       0
`define CMD_START       1
`define CMD_ABORT       2

// status fields
`define ST_RUNNING      0
`define ST_WAIT_EVENT   1
`define ST_ERR_SIZE     2
`define ST_ERR_AUTO     3
`define ST_ERR_PRET     4

// sizes in readings, pre-event share in percent
`define POINTS_MIN      15'h0002
`define POINTS_RESET    15'h0064
`define MAX_FULL_0      15'h00FA
`define MAX_FULL_1      15'h0578
`define MAX_FULL_2      15'h1770
`define MAX_LEAN_0      15'h0352
`define MAX_LEAN_1      15'h1B58
`define MAX_LEAN_2      15'h7530
`define PCT_MAX         7'h64
`define PCT_RESET       7'h32

// memory bytes
`define MEM_BYTES_0     32'h00000D48
`define MEM_BYTES_1     32'h00006D60
`define MEM_BYTES_2     32'h0001D4C0
`define BYTES_FULL_0    17'h0000D
`define BYTES_FULL_1    17'h00014
`define BYTES_FULL_2    17'h00014
`define BYTES_LEAN      17'h00004

`endif

// [rtl/reading_store_pkg.sv]
package reading_store_pkg;
	typedef enum logic [1:0] {
		storage_off       = 2'h0,
		fill_once         = 2'h1,
		wrap_always       = 2'h2,
		event_window_mode = 2'h3
	} mode_t;
	typedef enum logic [1:0] {
		feed_none   = 2'h0,
		raw_source  = 2'h1,
		math_source = 2'h2
	} feed_t;
	typedef enum logic [0:0] {
		set_stamped = 1'h0,
		set_lean    = 1'h1
	} element_set_t;
	typedef enum logic [2:0] {
		run_idle  = 3'h0,
		run_fill  = 3'h1,
		run_wrap  = 3'h2,
		run_pre   = 3'h3,
		run_post  = 3'h4
	} run_t;
endpackage

// [rtl/reading_store_event_window_mode_buffer.sv]
`timescale 1ns/100ps
`include "reading_store_consts.svh"

module reading_store_event_window_mode_buffer
	import reading_store_pkg::*;
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// reading stream
	input  wire logic        sample_valid_in,
	input  wire logic [31:0] raw_in,
	input  wire logic [31:0] math_in,
	input  wire logic [3:0]  func_in,
	input  wire logic [7:0]  chan_in,
	// trigger model
	input  wire logic [16:0] measure_count_in,
	input  wire logic        measure_inf_in,
	input  wire logic        event_in,
	// straps
	input  wire logic [1:0]  mem_option_in,
	// state
	output logic             run_active_out
);
	localparam int DEPTH = 30000;

	// storage
	logic [31:0] mem_reading [0:DEPTH-1];
	logic [26:0] mem_meta    [0:DEPTH-1];
	logic [31:0] mem_time    [0:DEPTH-1];

	// settings
	mode_t        mode_r;
	feed_t        feed_r;
	element_set_t eset_r;
	logic         auto_r;
	logic [14:0]  points_r;
	logic [6:0]   pct_r;
	logic [14:0]  pre_cnt_r;
	logic         pre_by_cnt_r;
	logic [2:0]   err_r;
	logic [14:0]  rd_idx_r;
	logic [31:0]  prdata_r;

	// run state
	run_t         st_r;
	logic [14:0]  wr_idx_r;
	logic [14:0]  post_left_r;
	logic [14:0]  fill_r;
	logic         first_r;
	logic [31:0]  tick_r;
	logic [31:0]  base_r;

	// synchronisers
	logic         ev_s1_r;
	logic         ev_s2_r;
	logic         ev_s3_r;
	logic [1:0]   opt_s1_r;
	logic [1:0]   opt_s2_r;

	function automatic logic [14:0] share_of(input logic [14:0] pts, input logic [6:0] pct);
		logic [21:0] prod;
		prod = 22'(pts) * 22'(pct);
		return 15'(prod / 22'(`PCT_MAX));
	endfunction

	// apb decode
	wire         setup     = psel_in & ~penable_in;
	wire         wr_acc    = psel_in & penable_in & pwrite_in;
	wire         hit_ctrl  = paddr_in == `OFS_CTRL;
	wire         hit_pts   = paddr_in == `OFS_POINTS;
	wire         hit_pct   = paddr_in == `OFS_PRET_PCT;
	wire         hit_reads = paddr_in == `OFS_PRET_READS;
	wire         hit_cmd   = paddr_in == `OFS_CMD;
	wire         hit_stat  = paddr_in == `OFS_STATUS;
	wire         hit_avail = paddr_in == `OFS_FREE_AVAIL;
	wire         hit_used  = paddr_in == `OFS_FREE_USED;
	wire         hit_ridx  = paddr_in == `OFS_RD_INDEX;
	wire         hit_rrd   = paddr_in == `OFS_RD_READING;
	wire         hit_rmeta = paddr_in == `OFS_RD_META;
	wire         hit_rtime = paddr_in == `OFS_RD_TIME;
	wire         hit_any   = hit_ctrl | hit_pts | hit_pct | hit_reads | hit_cmd | hit_stat |
	                         hit_avail | hit_used | hit_ridx | hit_rrd | hit_rmeta | hit_rtime;
	wire         w_ctrl    = wr_acc & hit_ctrl;
	wire         w_pts     = wr_acc & hit_pts;
	wire         w_pct     = wr_acc & hit_pct;
	wire         w_reads   = wr_acc & hit_reads;
	wire         w_cmd     = wr_acc & hit_cmd;
	wire         w_stat    = wr_acc & hit_stat;
	wire         w_ridx    = wr_acc & hit_ridx;
	wire         cmd_clear = w_cmd & pwdata_in[`CMD_CLEAR];
	wire         cmd_start = w_cmd & pwdata_in[`CMD_START];
	wire         cmd_abort = w_cmd & pwdata_in[`CMD_ABORT];

	// capacity by option and element set
	wire  [14:0] max_full  = (opt_s2_r == 2'h1) ? `MAX_FULL_1 :
	                         (opt_s2_r == 2'h2) ? `MAX_FULL_2 : `MAX_FULL_0;
	wire  [14:0] max_lean  = (opt_s2_r == 2'h1) ? `MAX_LEAN_1 :
	                         (opt_s2_r == 2'h2) ? `MAX_LEAN_2 : `MAX_LEAN_0;
	wire  [14:0] max_pts   = (eset_r == set_lean) ? max_lean : max_full;
	wire  [31:0] mem_total = (opt_s2_r == 2'h1) ? `MEM_BYTES_1 :
	                         (opt_s2_r == 2'h2) ? `MEM_BYTES_2 : `MEM_BYTES_0;
	wire  [16:0] bpr_full  = (opt_s2_r == 2'h1) ? `BYTES_FULL_1 :
	                         (opt_s2_r == 2'h2) ? `BYTES_FULL_2 : `BYTES_FULL_0;
	wire  [16:0] bpr       = (eset_r == set_lean) ? `BYTES_LEAN : bpr_full;
	wire  [31:0] used      = 32'({17'h0, fill_r} * {15'h0, bpr});
	wire  [31:0] avail     = (used > mem_total) ? 32'h0 : mem_total - used;

	// size requests
	wire  [14:0] req_pts   = pwdata_in[14:0];
	wire         pts_ok    = (pwdata_in[31:15] == 17'h0) && (req_pts >= `POINTS_MIN) &&
	                         (req_pts <= max_pts);
	wire  [14:0] cnt_lo    = (measure_count_in[16:15] != 2'h0) ? 15'h7FFF :
	                         measure_count_in[14:0];
	wire  [14:0] auto_pts  = (cnt_lo > max_pts) ? max_pts :
	                         (cnt_lo < `POINTS_MIN) ? `POINTS_MIN : cnt_lo;
	wire         auto_bad  = w_ctrl & pwdata_in[`CTRL_AUTO] & ~auto_r & measure_inf_in;
	wire         pct_ok    = (pwdata_in[31:7] == 25'h0) && (pwdata_in[6:0] <= `PCT_MAX);
	wire         reads_ok  = (pwdata_in[31:15] == 17'h0) && (req_pts <= points_r);
	wire  [14:0] pre_amt   = pre_by_cnt_r ? ((pre_cnt_r > points_r) ? points_r : pre_cnt_r) :
	                         share_of(points_r, pct_r);

	// sample path
	wire         in_run    = (st_r != run_idle);
	wire         ev_edge   = ev_s2_r & ~ev_s3_r;
	wire         ev_take   = (st_r == run_pre) & ev_edge;
	wire         accept    = sample_valid_in & (feed_r != feed_none) & in_run & ~ev_take &
	                         ~cmd_abort & ~cmd_clear & ((st_r != run_pre) || (pre_amt != 15'h0));
	wire  [14:0] idx_inc   = wr_idx_r + 15'h1;
	wire  [31:0] wr_read   = (feed_r == math_source) ? math_in : raw_in;
	wire  [31:0] wr_time   = first_r ? 32'h0 : tick_r - base_r;
	wire  [26:0] wr_meta   = {func_in, chan_in, wr_idx_r};
	wire  [31:0] rd_reading = (rd_idx_r < 15'(DEPTH)) ? mem_reading[rd_idx_r] : 32'h0;
	wire  [26:0] rd_meta    = (rd_idx_r < 15'(DEPTH)) ? mem_meta[rd_idx_r] : 27'h0;
	wire  [31:0] rd_time    = (rd_idx_r < 15'(DEPTH) && eset_r == set_stamped) ?
	                          mem_time[rd_idx_r] : 32'h0;
	wire  [31:0] rd_mux =
		hit_ctrl  ? {26'h0, auto_r, eset_r, feed_r, mode_r} :
		hit_pts   ? {17'h0, points_r} :
		hit_pct   ? {25'h0, pct_r} :
		hit_reads ? {17'h0, pre_amt} :
		hit_stat  ? {27'h0, err_r, st_r == run_pre, in_run} :
		hit_avail ? avail :
		hit_used  ? used :
		hit_ridx  ? {17'h0, rd_idx_r} :
		hit_rrd   ? rd_reading :
		hit_rmeta ? {5'h0, rd_meta} :
		hit_rtime ? rd_time : 32'h0;

	assign prdata_out     = prdata_r;
	assign pready_out     = 1'b1;
	assign pslverr_out    = psel_in & penable_in & ~hit_any;
	assign run_active_out = in_run;

	// input synchronisers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ev_s1_r  <= 1'b0;
			ev_s2_r  <= 1'b0;
			ev_s3_r  <= 1'b0;
			opt_s1_r <= 2'h0;
			opt_s2_r <= 2'h0;
		end else begin
			ev_s1_r  <= event_in;
			ev_s2_r  <= ev_s1_r;
			ev_s3_r  <= ev_s2_r;
			opt_s1_r <= mem_option_in;
			opt_s2_r <= opt_s1_r;
		end
	end

	// apb read data
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prdata_r <= 32'h0;
		end else if (setup) begin
			prdata_r <= pwrite_in ? 32'h0 : rd_mux;
		end
	end

	// settings, only cleared by the power-up reset pin
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_r       <= storage_off;
			feed_r       <= feed_none;
			eset_r       <= set_stamped;
			auto_r       <= 1'b0;
			points_r     <= `POINTS_RESET;
			pct_r        <= `PCT_RESET;
			pre_cnt_r    <= 15'h0;
			pre_by_cnt_r <= 1'b0;
			rd_idx_r     <= 15'h0;
		end else begin
			if (w_ctrl) begin
				mode_r <= mode_t'(pwdata_in[`CTRL_MODE_HI:`CTRL_MODE_LO]);
				feed_r <= (pwdata_in[`CTRL_FEED_HI:`CTRL_FEED_LO] == 2'h3) ? feed_r :
				          feed_t'(pwdata_in[`CTRL_FEED_HI:`CTRL_FEED_LO]);
				eset_r <= element_set_t'(pwdata_in[`CTRL_ELEMENT_SET_SELECT]);
				if (!auto_bad)
					auto_r <= pwdata_in[`CTRL_AUTO];
			end
			if (w_pts && pts_ok) begin
				points_r <= req_pts;
				auto_r   <= 1'b0;
			end else if (auto_r && !measure_inf_in) begin
				points_r <= auto_pts;
			end
			if (w_pct && pct_ok) begin
				pct_r        <= pwdata_in[6:0];
				pre_by_cnt_r <= 1'b0;
			end
			if (w_reads && reads_ok) begin
				pre_cnt_r    <= req_pts;
				pre_by_cnt_r <= 1'b1;
			end
			if (w_ridx)
				rd_idx_r <= pwdata_in[14:0];
		end
	end

	// sticky errors, write one to clear, a new error wins
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			err_r <= 3'h0;
		end else begin
			err_r <= (err_r & ~(w_stat ? pwdata_in[`ST_ERR_PRET:`ST_ERR_SIZE] : 3'h0)) |
			         {(w_reads & ~reads_ok) | (w_pct & ~pct_ok), auto_bad,
			          w_pts & ~pts_ok};
		end
	end

	// run sequencer
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r        <= run_idle;
			wr_idx_r    <= 15'h0;
			post_left_r <= 15'h0;
			fill_r      <= 15'h0;
			first_r     <= 1'b0;
			tick_r      <= 32'h0;
			base_r      <= 32'h0;
		end else begin
			tick_r <= tick_r + 32'h1;
			if (accept) begin
				first_r <= 1'b0;
				if (first_r)
					base_r <= tick_r;
				if (idx_inc > fill_r)
					fill_r <= idx_inc;
			end
			if (cmd_clear) begin
				st_r     <= run_idle;
				wr_idx_r <= 15'h0;
				fill_r   <= 15'h0;
			end else if (cmd_abort) begin
				st_r <= run_idle;
			end else if (cmd_start && !in_run) begin
				wr_idx_r <= 15'h0;
				first_r  <= 1'b1;
				case (mode_r)
					fill_once:         st_r <= run_fill;
					wrap_always:       st_r <= run_wrap;
					event_window_mode: st_r <= run_pre;
					default:           st_r <= run_idle;
				endcase
			end else if (ev_take) begin
				wr_idx_r    <= pre_amt;
				post_left_r <= points_r - pre_amt;
				if (points_r == pre_amt)
					st_r <= run_idle;
				else
					st_r <= run_post;
			end else if (accept) begin
				case (st_r)
					run_fill: begin
						wr_idx_r <= idx_inc;
						if (idx_inc >= points_r)
							st_r <= run_idle;
					end
					run_wrap: begin
						wr_idx_r <= (idx_inc >= points_r) ? 15'h0 : idx_inc;
					end
					run_pre: begin
						wr_idx_r <= (idx_inc >= pre_amt) ? 15'h0 : idx_inc;
					end
					run_post: begin
						wr_idx_r    <= idx_inc;
						post_left_r <= post_left_r - 15'h1;
						if (post_left_r == 15'h1)
							st_r <= run_idle;
					end
					default: st_r <= run_idle;
				endcase
			end
		end
	end

	// entry storage, no reset so earlier contents survive
	always_ff @(posedge clk_in) begin
		if (accept) begin
			mem_reading[wr_idx_r] <= wr_read;
			mem_meta[wr_idx_r]    <= wr_meta;
			mem_time[wr_idx_r]    <= wr_time;
		end
	end

	// checks
	property p_clear;
		@(posedge clk_in) disable iff (!rst_n_in) cmd_clear |=> (fill_r == 15'h0) && (used == 32'h0);
	endproperty
	a_clear: assert property (p_clear) else $error("clear left entries");

	property p_stamp_zero;
		@(posedge clk_in) disable iff (!rst_n_in) (accept && first_r) |-> (wr_time == 32'h0);
	endproperty
	a_stamp_zero: assert property (p_stamp_zero) else $error("first stamp not zero");

	property p_auto_follow;
		@(posedge clk_in) disable iff (!rst_n_in)
			(auto_r && !measure_inf_in && !w_pts && !w_ctrl) |=> (points_r == $past(auto_pts));
	endproperty
	a_auto_follow: assert property (p_auto_follow) else $error("size not following count");

	property p_size_cmd;
		@(posedge clk_in) disable iff (!rst_n_in)
			(w_pts && pts_ok) |=> !auto_r && points_r == $past(req_pts);
	endproperty
	a_size_cmd: assert property (p_size_cmd) else $error("size command mishandled");

	property p_auto_inf;
		@(posedge clk_in) disable iff (!rst_n_in) auto_bad |=> !auto_r && err_r[1];
	endproperty
	a_auto_inf: assert property (p_auto_inf) else $error("auto enabled with infinite count");

	property p_feed_none;
		@(posedge clk_in) disable iff (!rst_n_in)
			(feed_r == feed_none && !cmd_clear) |=> $stable(fill_r);
	endproperty
	a_feed_none: assert property (p_feed_none) else $error("store with source none");

	property p_post_end;
		@(posedge clk_in) disable iff (!rst_n_in)
			(st_r == run_post && accept && post_left_r == 15'h1 && !w_cmd) |=> st_r == run_idle;
	endproperty
	a_post_end: assert property (p_post_end) else $error("post part overran");

	property p_reads_bad;
		@(posedge clk_in) disable iff (!rst_n_in)
			(w_reads && !reads_ok) |=> $stable(pre_cnt_r) && err_r[2];
	endproperty
	a_reads_bad: assert property (p_reads_bad) else $error("oversized pre count taken");

	property p_size_bad;
		@(posedge clk_in) disable iff (!rst_n_in)
			(w_pts && !pts_ok && !auto_r) |=> $stable(points_r) && err_r[0];
	endproperty
	a_size_bad: assert property (p_size_bad) else $error("bad size taken");

	property p_pre_wrap;
		@(posedge clk_in) disable iff (!rst_n_in) (st_r == run_pre && accept) |-> wr_idx_r < pre_amt;
	endproperty
	a_pre_wrap: assert property (p_pre_wrap) else $error("pre write outside region");

	property p_range;
		@(posedge clk_in) disable iff (!rst_n_in) points_r >= `POINTS_MIN;
	endproperty
	a_range: assert property (p_range) else $error("size below minimum");
endmodule

// [verif/reading_feed_model.sv]
`timescale 1ns/100ps
module reading_feed_model (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// request from bench
	input  wire logic        load_in,
	input  wire logic [7:0]  count_in,
	input  wire logic        slow_in,
	output logic             idle_out,
	// reading stream
	output logic             valid_out,
	output logic      [31:0] raw_out,
	output logic      [31:0] math_out,
	output logic      [3:0]  func_out,
	output logic      [7:0]  chan_out
);
	logic [7:0] left_r;
	logic [7:0] seq_r;
	logic       gap_r;
	assign idle_out = (left_r == 8'h00);
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			left_r <= 8'h00;
			seq_r <= 8'h00;
			gap_r <= 1'b0;
			valid_out <= 1'b0;
			raw_out <= 32'h00000000;
			math_out <= 32'h00000000;
			func_out <= 4'h0;
			chan_out <= 8'h00;
		end else if (load_in) begin
			left_r <= count_in;
			gap_r <= 1'b0;
			valid_out <= 1'b0;
		end else if (left_r != 8'h00 && !gap_r) begin
			valid_out <= 1'b1;
			raw_out <= {24'hA00000, seq_r};
			math_out <= {24'hB00000, seq_r};
			func_out <= seq_r[3:0];
			chan_out <= seq_r;
			seq_r <= seq_r + 8'h01;
			left_r <= left_r - 8'h01;
			gap_r <= slow_in;
		end else begin
			// data lines toggle between readings
			valid_out <= 1'b0;
			gap_r <= 1'b0;
			raw_out <= ~raw_out;
			math_out <= ~math_out;
			func_out <= ~func_out;
			chan_out <= ~chan_out;
		end
	end
endmodule

// [verif/reading_store_event_window_mode_buffer_tb.sv]
`timescale 1ns/100ps
`include "reading_store_consts.svh"
module reading_store_event_window_mode_buffer_tb;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, perr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        valid, minf, ev, run_act, load, slow, midle;
	logic [1:0]  memopt;
	logic [31:0] raw, math;
	logic [3:0]  func;
	logic [7:0]  chan, req, seq;
	logic [16:0] mcount;
	int          miscompares, cmp_count;

	reading_store_event_window_mode_buffer i_dut (.clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.sample_valid_in(valid), .raw_in(raw), .math_in(math), .func_in(func),
		.chan_in(chan), .measure_count_in(mcount), .measure_inf_in(minf), .event_in(ev),
		.mem_option_in(memopt), .run_active_out(run_act));
	reading_feed_model i_feed (.clk_in(clk), .rst_n_in(rst_n), .load_in(load),
		.count_in(req), .slow_in(slow), .idle_out(midle), .valid_out(valid),
		.raw_out(raw), .math_out(math), .func_out(func), .chan_out(chan));

	always #4 clk = ~clk;

	task complete_run;
		$display("checks %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
		xfer(1'b0, a, 32'h00000000);
		chk(nm, e, q);
	endtask

	task automatic bit_chk(input logic [11:0] a, input int b, input logic e, input string nm);
		xfer(1'b0, a, 32'h00000000);
		chk(nm, {31'h0, e}, {31'h0, q[b]});
	endtask

	task automatic send(input logic [7:0] n, input logic s);
		req <= n;
		slow <= s;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		do begin
			@(posedge clk);
		end while (midle !== 1'b1);
		repeat (2) @(posedge clk);
		seq = seq + n;
	endtask

	task automatic ent(input logic [14:0] i, input logic [31:0] v, input logic [7:0] s);
		wr(`OFS_RD_INDEX, {17'h0, i});
		rchk(`OFS_RD_READING, v, "reading");
		rchk(`OFS_RD_META, {5'h00, s[3:0], s, i}, "meta");
	endtask

	task automatic t_reset;
		rchk(`OFS_CTRL, 32'h00000000, "ctrl");
		rchk(`OFS_POINTS, `POINTS_RESET, "points");
		rchk(`OFS_PRET_PCT, `PCT_RESET, "pct");
		chk("slverr_ok", 32'h0, {31'h0, perr});
		rchk(12'h030, 32'h00000000, "unmapped");
		chk("slverr_bad", 32'h1, {31'h0, perr});
		$display("reset test done");
	endtask

	task automatic t_size;
		wr(`OFS_POINTS, 32'h00000001);
		bit_chk(`OFS_STATUS, `ST_ERR_SIZE, 1'b1, "size_err");
		rchk(`OFS_POINTS, `POINTS_RESET, "points_low");
		wr(`OFS_POINTS, `MAX_FULL_0 + 32'h1);
		rchk(`OFS_POINTS, `POINTS_RESET, "points_high");
		wr(`OFS_POINTS, `MAX_FULL_0);
		rchk(`OFS_POINTS, `MAX_FULL_0, "points_max");
		wr(`OFS_POINTS, `POINTS_MIN);
		rchk(`OFS_POINTS, `POINTS_MIN, "points_min");
		wr(`OFS_CTRL, 32'h00000010);
		wr(`OFS_POINTS, `MAX_LEAN_0);
		rchk(`OFS_POINTS, `MAX_LEAN_0, "lean_max");
		wr(`OFS_POINTS, `MAX_LEAN_0 + 32'h1);
		rchk(`OFS_POINTS, `MAX_LEAN_0, "lean_high");
		wr(`OFS_STATUS, 32'h0000001C);
		bit_chk(`OFS_STATUS, `ST_ERR_SIZE, 1'b0, "size_err_clr");
		$display("size test done");
	endtask

	task automatic t_opt;
		wr(`OFS_CTRL, 32'h00000000);
		memopt <= 2'h1;
		repeat (4) @(posedge clk);
		wr(`OFS_POINTS, `MAX_FULL_1);
		rchk(`OFS_POINTS, `MAX_FULL_1, "opt1_max");
		wr(`OFS_POINTS, `MAX_FULL_1 + 32'h1);
		rchk(`OFS_POINTS, `MAX_FULL_1, "opt1_high");
		memopt <= 2'h2;
		repeat (4) @(posedge clk);
		wr(`OFS_POINTS, `MAX_FULL_2);
		rchk(`OFS_POINTS, `MAX_FULL_2, "opt2_max");
		wr(`OFS_CTRL, 32'h00000010);
		wr(`OFS_POINTS, `MAX_LEAN_2);
		rchk(`OFS_POINTS, `MAX_LEAN_2, "opt2_lean");
		rchk(`OFS_FREE_AVAIL, `MEM_BYTES_2, "opt2_avail");
		memopt <= 2'h1;
		repeat (4) @(posedge clk);
		wr(`OFS_POINTS, `MAX_LEAN_1);
		rchk(`OFS_POINTS, `MAX_LEAN_1, "opt1_lean");
		memopt <= 2'h0;
		repeat (4) @(posedge clk);
		wr(`OFS_STATUS, 32'h0000001C);
		$display("option test done");
	endtask

	task automatic t_auto;
		mcount <= 17'd37;
		wr(`OFS_CTRL, 32'h00000030);
		rchk(`OFS_POINTS, 32'd37, "auto_size");
		mcount <= 17'd40;
		repeat (4) @(posedge clk);
		rchk(`OFS_POINTS, 32'd40, "auto_follow");
		wr(`OFS_POINTS, 32'd20);
		rchk(`OFS_POINTS, 32'd20, "size_cmd");
		bit_chk(`OFS_CTRL, `CTRL_AUTO, 1'b0, "auto_off");
		wr(`OFS_CTRL, 32'h00000030);
		wr(`OFS_CTRL, 32'h00000010);
		mcount <= 17'd50;
		repeat (4) @(posedge clk);
		rchk(`OFS_POINTS, 32'd40, "auto_disabled");
		minf <= 1'b1;
		wr(`OFS_CTRL, 32'h00000030);
		bit_chk(`OFS_CTRL, `CTRL_AUTO, 1'b0, "auto_inf");
		bit_chk(`OFS_STATUS, `ST_ERR_AUTO, 1'b1, "auto_err");
		rchk(`OFS_POINTS, 32'd40, "inf_size");
		minf <= 1'b0;
		wr(`OFS_STATUS, 32'h0000001C);
		$display("auto test done");
	endtask

	task automatic t_fill;
		logic [7:0] s0, s1;
		wr(`OFS_CTRL, 32'h00000005);
		wr(`OFS_POINTS, 32'd4);
		wr(`OFS_CMD, 32'h00000001);
		rchk(`OFS_FREE_USED, 32'h0, "used_clear");
		wr(`OFS_CMD, 32'h00000002);
		chk("running", 32'h1, {31'h0, run_act});
		s0 = seq;
		send(8'd6, 1'b1);
		chk("stopped", 32'h0, {31'h0, run_act});
		rchk(`OFS_FREE_USED, `BYTES_FULL_0 * 4, "used");
		rchk(`OFS_FREE_AVAIL, `MEM_BYTES_0 - `BYTES_FULL_0 * 4, "avail");
		ent(15'd0, {24'hA00000, s0}, s0);
		ent(15'd3, {24'hA00000, s0 + 8'd3}, s0 + 8'd3);
		rchk(`OFS_RD_TIME, 32'd6, "stamp3");
		wr(`OFS_RD_INDEX, 32'h0);
		rchk(`OFS_RD_TIME, 32'h0, "stamp0");
		wr(`OFS_CTRL, 32'h00000009);
		wr(`OFS_CMD, 32'h00000002);
		s1 = seq;
		send(8'd2, 1'b0);
		wr(`OFS_CMD, 32'h00000004);
		chk("aborted", 32'h0, {31'h0, run_act});
		ent(15'd1, {24'hB00000, s1 + 8'd1}, s1 + 8'd1);
		ent(15'd2, {24'hA00000, s0 + 8'd2}, s0 + 8'd2);
		wr(`OFS_CTRL, 32'h00000001);
		wr(`OFS_CMD, 32'h00000001);
		wr(`OFS_CMD, 32'h00000002);
		send(8'd3, 1'b0);
		rchk(`OFS_FREE_USED, 32'h0, "used_none");
		wr(`OFS_CMD, 32'h00000004);
		wr(`OFS_CTRL, 32'h00000004);
		wr(`OFS_CMD, 32'h00000002);
		chk("off_idle", 32'h0, {31'h0, run_act});
		$display("fill test done");
	endtask

	task automatic t_wrap_pre;
		logic [7:0] s;
		wr(`OFS_POINTS, 32'd2);
		wr(`OFS_CTRL, 32'h00000006);
		wr(`OFS_CMD, 32'h00000002);
		s = seq;
		send(8'd3, 1'b0);
		chk("wrap_run", 32'h1, {31'h0, run_act});
		ent(15'd0, {24'hA00000, s + 8'd2}, s + 8'd2);
		wr(`OFS_CMD, 32'h00000004);
		wr(`OFS_POINTS, 32'd4);
		wr(`OFS_PRET_READS, 32'd2);
		wr(`OFS_PRET_READS, 32'd5);
		bit_chk(`OFS_STATUS, `ST_ERR_PRET, 1'b1, "pret_err");
		rchk(`OFS_PRET_READS, 32'd2, "pret_reads");
		wr(`OFS_STATUS, 32'h0000001C);
		wr(`OFS_CTRL, 32'h00000007);
		wr(`OFS_CMD, 32'h00000001);
		wr(`OFS_CMD, 32'h00000002);
		s = seq;
		send(8'd5, 1'b0);
		bit_chk(`OFS_STATUS, `ST_WAIT_EVENT, 1'b1, "waiting");
		ev <= 1'b1;
		repeat (6) @(posedge clk);
		ev <= 1'b0;
		chk("pre_run", 32'h1, {31'h0, run_act});
		send(8'd3, 1'b0);
		chk("post_stop", 32'h0, {31'h0, run_act});
		ent(15'd0, {24'hA00000, s + 8'd4}, s + 8'd4);
		ent(15'd1, {24'hA00000, s + 8'd3}, s + 8'd3);
		ent(15'd2, {24'hA00000, s + 8'd5}, s + 8'd5);
		ent(15'd3, {24'hA00000, s + 8'd6}, s + 8'd6);
		$display("pre-event test done");
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		complete_run;
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{psel, penable, pwrite, minf, ev, load, slow} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		mcount = 17'h00064;
		req = 8'h00;
		memopt = 2'h0;
		seq = 8'h00;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset;
		t_size;
		t_opt;
		t_auto;
		wr(`OFS_CTRL, 32'h00000000);
		t_fill;
		t_wrap_pre;
		complete_run;
	end
endmodule
